// File: hdl/pin_sync.sv
// Three-stage synchroniser for asynchronous pins with agreement filter.
// Assumes raw pins are asynchronous to core_clk.
`timescale 1ns/1ns
module pin_sync (
  // Clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               rst_b,
  // Raw pins {lowpower_req, standby, en, sda, scl}
  input  wire logic [regbank_pkg::SYNC_WIDTH-1:0] raw_in,
  // Filtered levels
  pin_sync_if.sync                                levels
);

  logic [regbank_pkg::SYNC_WIDTH-1:0] s1_r;
  logic [regbank_pkg::SYNC_WIDTH-1:0] s2_r;
  logic [regbank_pkg::SYNC_WIDTH-1:0] s3_r;
  logic [regbank_pkg::SYNC_WIDTH-1:0] stable_r;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a bit only when stages two and three agree, rejecting one-cycle glitches
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stable_r <= '1;
    end else begin
      for (int i = 0; i < regbank_pkg::SYNC_WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          stable_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign levels.scl          = stable_r[0];
  assign levels.sda          = stable_r[1];
  assign levels.en_pin       = stable_r[2];
  assign levels.standby_pin  = stable_r[3];
  assign levels.lowpower_req = stable_r[4];

endmodule

// File: hdl/pin_sync_if.sv
// Interface carrying synchronised pin levels to the register bank.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
interface pin_sync_if;
  logic scl;
  logic sda;
  logic en_pin;
  logic standby_pin;
  logic lowpower_req;

  modport sync (output scl, sda, en_pin, standby_pin, lowpower_req);
  modport user (input  scl, sda, en_pin, standby_pin, lowpower_req);
endinterface

// File: hdl/regbank_pkg.sv
// Constants, field layout and types for the paged regulator control bank.
// Assumes one 25 MHz core clock and a synchronous active-low reset.
package regbank_pkg;

  // ----------------------------------------------------------------
  // Register offsets (8-bit register address space)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_THREE_CTRL  = 8'h70;
  localparam logic [7:0] ADDR_FOUR_CTRL   = 8'h71;
  localparam logic [7:0] ADDR_EVENT_STAT  = 8'h72;
  localparam logic [7:0] ADDR_PAGE_SEL    = 8'h7F;
  localparam logic [7:0] ADDR_EXT_BASE    = 8'h80;
  localparam logic [7:0] ADDR_EXT_SCRATCH = 8'h80;

  // ----------------------------------------------------------------
  // Page codes
  // ----------------------------------------------------------------
  localparam logic [3:0] PAGE_FUNC = 4'h0;
  localparam logic [3:0] PAGE_EXT1 = 4'h1;
  localparam logic [3:0] PAGE_EXT2 = 4'h2;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_OFFMODE = 7;
  localparam int unsigned BIT_LOWPWR  = 6;
  localparam int unsigned BIT_STBY    = 5;
  localparam int unsigned BIT_ON      = 4;
  localparam int unsigned VSEL_MSB    = 3;
  localparam int unsigned STAT_OFFEVT = 0;
  localparam int unsigned STAT_STBEVT = 1;

  // ----------------------------------------------------------------
  // Values after reset and built-in defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CTRL_BUILTIN   = 8'h10;
  localparam logic [3:0] PAGE_RESET     = 4'h0;
  localparam logic [1:0] STAT_RESET     = 2'h0;
  localparam logic [7:0] SCRATCH_RESET  = 8'h00;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  // ----------------------------------------------------------------
  // Control bus
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR      = 7'h08;  // Arbitrary bus address
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int unsigned SYNC_WIDTH   = 5;

  // Bus engine states, Gray coded along the write path and the read byte loop
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ACK_ADDR = 4'h3,
    ST_REGADDR  = 4'h2,
    ST_ACK_REG  = 4'h6,
    ST_WDATA    = 4'h7,
    ST_ACK_W    = 4'h5,
    ST_RDATA    = 4'h4,
    ST_ACK_R    = 4'hC
  } bus_state_t;

endpackage

// File: hdl/regulator_ctrl_bank.sv
// Paged control register bank for two linear regulators, reached over a two-wire bus.
// Assumes open-drain bus pins resolved outside and a fuse block valid at reset release.
//
// Notes on behaviour
// - Reg three offmode 1: sleep on turn-off
// - Reg three bit 6 permits low power
// - Reg three standby bit: off in standby
// - Reg three bit 4 switches it on
// - Reg three bits 3:0 hold voltage code
// - Reg four offmode 1: sleep on turn-off
// - Reg four bit 6 permits low power
// - Reg four standby bit: off in standby
// - Reg four bit 4 switches it on
// - Reg four bits 3:0 hold voltage code
// - Page codes 0,1,2 select pages
// - Low half common, high half paged
// - Functional registers ignore page selection
// - Other page codes map nothing
// - Eight-bit addresses and data
// - Unmapped reads zero, writes ignored
// - Write-one clears status bits, zero keeps
// - Load fuse or built-in defaults at start
// - Fused bits writable only after load
// - Offmode 0: fully off on turn-off
// - Standby bit 0 keeps regulator on
`timescale 1ns/1ns
module regulator_ctrl_bank (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Two-wire control bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Device mode pins
  input  wire logic       en_pin,
  input  wire logic       standby_pin,
  input  wire logic       lowpower_req,
  // Fuse settings
  input  wire logic       fuse_program_supply,
  input  wire logic [4:0] fuse_reg_three,
  input  wire logic [4:0] fuse_reg_four,
  // Regulator three controls
  output logic            reg_three_on,
  output logic            reg_three_sleep,
  output logic            reg_three_lowpower,
  output logic [3:0]      reg_three_vsel,
  // Regulator four controls
  output logic            reg_four_on,
  output logic            reg_four_sleep,
  output logic            reg_four_lowpower,
  output logic [3:0]      reg_four_vsel
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pin_sync_if                  pins ();
  regbank_pkg::bus_state_t     state_r;
  logic [3:0]                  cnt_r;
  logic [7:0]                  shift_r;
  logic [7:0]                  ptr_r;
  logic                        rw_r;
  logic                        nack_r;
  logic                        pull_r;
  logic                        scl_q_r;
  logic                        sda_q_r;
  logic                        en_q_r;
  logic                        stb_q_r;
  logic [7:0]                  three_r;
  logic [7:0]                  four_r;
  logic [3:0]                  page_r;
  logic [1:0]                  stat_r;
  logic [1:0]                  stat_nxt;
  logic [7:0]                  scratch1_r;
  logic [7:0]                  scratch2_r;
  logic                        loaded_r;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_cond;
  logic                        stop_cond;
  logic                        wr_stb;
  logic [7:0]                  rd_val;
  logic [2:0]                  mode_three;
  logic [2:0]                  mode_four;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  pin_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .raw_in   ({lowpower_req, standby_pin, en_pin, sda_in, scl_in}),
    .levels   (pins)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Low half ignores page; high half needs page 1 or 2
  function automatic logic is_mapped(input logic [7:0] a, input logic [3:0] pg);
    if (a < regbank_pkg::ADDR_EXT_BASE) begin
      is_mapped = (a == regbank_pkg::ADDR_THREE_CTRL) || (a == regbank_pkg::ADDR_FOUR_CTRL) ||
                  (a == regbank_pkg::ADDR_EVENT_STAT) || (a == regbank_pkg::ADDR_PAGE_SEL);
    end else begin
      is_mapped = (a == regbank_pkg::ADDR_EXT_SCRATCH) &&
                  (pg == regbank_pkg::PAGE_EXT1 || pg == regbank_pkg::PAGE_EXT2);
    end
  endfunction

  // Regulator state {on, sleep, lowpower} from control bits and device mode
  function automatic logic [2:0] reg_mode(input logic [7:0] c, input logic en,
                                          input logic stby, input logic lpreq);
    logic on;
    on = 1'b0;
    if (!en) begin
      reg_mode = {1'b0, c[regbank_pkg::BIT_OFFMODE], 1'b0};
    end else begin
      on = c[regbank_pkg::BIT_ON] && !(stby && c[regbank_pkg::BIT_STBY]);
      reg_mode = {on, 1'b0, on && lpreq && c[regbank_pkg::BIT_LOWPWR]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  // Previous filtered levels for edge detection
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      en_q_r  <= 1'b1;
      stb_q_r <= 1'b1;  // Matches synchroniser reset level, no false standby event
    end else begin
      scl_q_r <= pins.scl;
      sda_q_r <= pins.sda;
      en_q_r  <= pins.en_pin;
      stb_q_r <= pins.standby_pin;
    end
  end

  assign scl_rise   = pins.scl && !scl_q_r;
  assign scl_fall   = !pins.scl && scl_q_r;
  assign start_cond = pins.scl && scl_q_r && sda_q_r && !pins.sda;
  assign stop_cond  = pins.scl && scl_q_r && !sda_q_r && pins.sda;
  assign wr_stb     = scl_fall && (state_r == regbank_pkg::ST_WDATA) &&
                      (cnt_r == regbank_pkg::BITS_PER_BYTE);

  // ----------------------------------------------------------------
  // Bus byte engine
  // ----------------------------------------------------------------
  // Sample on rising clock edge, drive on falling edge so data is stable while high
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_r <= regbank_pkg::ST_IDLE;
      cnt_r   <= 4'h0;
      shift_r <= 8'h00;
      ptr_r   <= 8'h00;
      rw_r    <= 1'b0;
      nack_r  <= 1'b0;
      pull_r  <= 1'b0;
    end else if (start_cond) begin
      state_r <= regbank_pkg::ST_ADDR;
      cnt_r   <= 4'h0;
      pull_r  <= 1'b0;
    end else if (stop_cond) begin
      state_r <= regbank_pkg::ST_IDLE;
      pull_r  <= 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        regbank_pkg::ST_ADDR, regbank_pkg::ST_REGADDR, regbank_pkg::ST_WDATA: begin
          shift_r <= {shift_r[6:0], pins.sda};
          cnt_r   <= cnt_r + 4'h1;
        end
        regbank_pkg::ST_RDATA: begin
          cnt_r   <= cnt_r + 4'h1;
        end
        regbank_pkg::ST_ACK_R: begin
          nack_r  <= pins.sda;
        end
        default: begin
          cnt_r   <= cnt_r;
        end
      endcase
    end else if (scl_fall) begin
      case (state_r)
        regbank_pkg::ST_ADDR: begin
          if (cnt_r == regbank_pkg::BITS_PER_BYTE) begin
            if (shift_r[7:1] == regbank_pkg::DEV_ADDR) begin
              state_r <= regbank_pkg::ST_ACK_ADDR;
              rw_r    <= shift_r[0];
              pull_r  <= 1'b1;
            end else begin
              state_r <= regbank_pkg::ST_IDLE;
            end
          end
        end
        regbank_pkg::ST_ACK_ADDR: begin
          cnt_r <= 4'h0;
          if (rw_r) begin
            state_r <= regbank_pkg::ST_RDATA;
            shift_r <= rd_val;
            pull_r  <= !rd_val[7];
          end else begin
            state_r <= regbank_pkg::ST_REGADDR;
            pull_r  <= 1'b0;
          end
        end
        regbank_pkg::ST_REGADDR: begin
          if (cnt_r == regbank_pkg::BITS_PER_BYTE) begin
            state_r <= regbank_pkg::ST_ACK_REG;
            ptr_r   <= shift_r;
            pull_r  <= 1'b1;
          end
        end
        regbank_pkg::ST_ACK_REG, regbank_pkg::ST_ACK_W: begin
          state_r <= regbank_pkg::ST_WDATA;
          cnt_r   <= 4'h0;
          pull_r  <= 1'b0;
        end
        regbank_pkg::ST_WDATA: begin
          if (cnt_r == regbank_pkg::BITS_PER_BYTE) begin
            state_r <= regbank_pkg::ST_ACK_W;
            ptr_r   <= ptr_r + 8'h01;
            pull_r  <= 1'b1;
          end
        end
        regbank_pkg::ST_RDATA: begin
          if (cnt_r == regbank_pkg::BITS_PER_BYTE) begin
            state_r <= regbank_pkg::ST_ACK_R;
            ptr_r   <= ptr_r + 8'h01;
            pull_r  <= 1'b0;
          end else begin
            pull_r  <= !shift_r[3'(7 - cnt_r)];
          end
        end
        regbank_pkg::ST_ACK_R: begin
          cnt_r <= 4'h0;
          if (nack_r) begin
            state_r <= regbank_pkg::ST_IDLE;
            pull_r  <= 1'b0;
          end else begin
            state_r <= regbank_pkg::ST_RDATA;
            shift_r <= rd_val;
            pull_r  <= !rd_val[7];
          end
        end
        default: begin
          state_r <= regbank_pkg::ST_IDLE;
          pull_r  <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = pull_r;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Unmapped addresses and unused bits read as zero
  always_comb begin
    rd_val = regbank_pkg::READ_ZERO;
    if (is_mapped(ptr_r, page_r)) begin
      if (ptr_r >= regbank_pkg::ADDR_EXT_BASE) begin
        rd_val = (page_r == regbank_pkg::PAGE_EXT1) ? scratch1_r : scratch2_r;
      end else if (ptr_r == regbank_pkg::ADDR_THREE_CTRL) begin
        rd_val = three_r;
      end else if (ptr_r == regbank_pkg::ADDR_FOUR_CTRL) begin
        rd_val = four_r;
      end else if (ptr_r == regbank_pkg::ADDR_EVENT_STAT) begin
        rd_val = {6'h00, stat_r};
      end else begin
        rd_val = {4'h0, page_r};
      end
    end
  end

  // ----------------------------------------------------------------
  // Regulator control registers
  // ----------------------------------------------------------------
  // Fused defaults load once after release; bus writes wait for that load
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      three_r  <= regbank_pkg::CTRL_RESET;
      four_r   <= regbank_pkg::CTRL_RESET;
      loaded_r <= 1'b0;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      three_r  <= fuse_program_supply ? regbank_pkg::CTRL_BUILTIN : {3'h0, fuse_reg_three};
      four_r   <= fuse_program_supply ? regbank_pkg::CTRL_BUILTIN : {3'h0, fuse_reg_four};
    end else if (wr_stb && ptr_r == regbank_pkg::ADDR_THREE_CTRL) begin
      three_r <= shift_r;
    end else if (wr_stb && ptr_r == regbank_pkg::ADDR_FOUR_CTRL) begin
      four_r  <= shift_r;
    end
  end

  // Page register and per-page scratch; page only steers the high half
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      page_r     <= regbank_pkg::PAGE_RESET;
      scratch1_r <= regbank_pkg::SCRATCH_RESET;
      scratch2_r <= regbank_pkg::SCRATCH_RESET;
    end else if (wr_stb && is_mapped(ptr_r, page_r)) begin
      if (ptr_r == regbank_pkg::ADDR_PAGE_SEL) begin
        page_r <= shift_r[3:0];
      end else if (ptr_r >= regbank_pkg::ADDR_EXT_BASE && page_r == regbank_pkg::PAGE_EXT1) begin
        scratch1_r <= shift_r;
      end else if (ptr_r >= regbank_pkg::ADDR_EXT_BASE) begin
        scratch2_r <= shift_r;
      end
    end
  end

  // Event flags: a new event wins over a same-cycle clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stb && ptr_r == regbank_pkg::ADDR_EVENT_STAT) begin
      stat_nxt = stat_r & ~shift_r[1:0];
    end
    stat_nxt[regbank_pkg::STAT_OFFEVT] = stat_nxt[regbank_pkg::STAT_OFFEVT] ||
                                         (en_q_r && !pins.en_pin);
    stat_nxt[regbank_pkg::STAT_STBEVT] = stat_nxt[regbank_pkg::STAT_STBEVT] ||
                                         (!stb_q_r && pins.standby_pin);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stat_r <= regbank_pkg::STAT_RESET;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Regulator outputs
  // ----------------------------------------------------------------
  assign mode_three = reg_mode(three_r, pins.en_pin, pins.standby_pin, pins.lowpower_req);
  assign mode_four  = reg_mode(four_r, pins.en_pin, pins.standby_pin, pins.lowpower_req);

  // Registered so the analog side sees no decode glitches
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {reg_three_on, reg_three_sleep, reg_three_lowpower} <= 3'h0;
      {reg_four_on, reg_four_sleep, reg_four_lowpower}    <= 3'h0;
      reg_three_vsel <= 4'h0;
      reg_four_vsel  <= 4'h0;
    end else begin
      {reg_three_on, reg_three_sleep, reg_three_lowpower} <= mode_three;
      {reg_four_on, reg_four_sleep, reg_four_lowpower}    <= mode_four;
      reg_three_vsel <= three_r[regbank_pkg::VSEL_MSB:0];
      reg_four_vsel  <= four_r[regbank_pkg::VSEL_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_three_write;
    wr_stb && loaded_r && ptr_r == regbank_pkg::ADDR_THREE_CTRL;
  endsequence

  sequence s_page_write;
    wr_stb && ptr_r == regbank_pkg::ADDR_PAGE_SEL;
  endsequence

  property p_three_vsel;
    @(posedge core_clk) disable iff (!rst_b)
    s_three_write |-> ##2 reg_three_vsel == $past(shift_r[3:0], 2);
  endproperty
  a_three_vsel: assert property (p_three_vsel) else $error("reg three vsel not updated");

  property p_three_sleep;
    @(posedge core_clk) disable iff (!rst_b)
    (!pins.en_pin && three_r[regbank_pkg::BIT_OFFMODE]) |=> reg_three_sleep && !reg_three_on;
  endproperty
  a_three_sleep: assert property (p_three_sleep) else $error("reg three not asleep");

  property p_four_off;
    @(posedge core_clk) disable iff (!rst_b)
    (!pins.en_pin && !four_r[regbank_pkg::BIT_OFFMODE]) |=> !reg_four_sleep && !reg_four_on;
  endproperty
  a_four_off: assert property (p_four_off) else $error("reg four not fully off");

  property p_three_stby;
    @(posedge core_clk) disable iff (!rst_b)
    (pins.en_pin && pins.standby_pin && three_r[regbank_pkg::BIT_STBY]) |=> !reg_three_on;
  endproperty
  a_three_stby: assert property (p_three_stby) else $error("reg three on in standby");

  property p_four_on;
    @(posedge core_clk) disable iff (!rst_b)
    (pins.en_pin && four_r[regbank_pkg::BIT_ON] && !four_r[regbank_pkg::BIT_STBY])
      |=> reg_four_on;
  endproperty
  a_four_on: assert property (p_four_on) else $error("reg four not on");

  property p_four_lowpwr;
    @(posedge core_clk) disable iff (!rst_b)
    reg_four_lowpower |-> $past(four_r[regbank_pkg::BIT_LOWPWR]) && reg_four_on;
  endproperty
  a_four_lowpwr: assert property (p_four_lowpwr) else $error("reg four low power not permitted");

  property p_page_readback;
    @(posedge core_clk) disable iff (!rst_b)
    s_page_write |=> page_r == $past(shift_r[3:0]);
  endproperty
  a_page_readback: assert property (p_page_readback) else $error("page readback wrong");

  property p_unmapped_zero;
    @(posedge core_clk) disable iff (!rst_b)
    !is_mapped(ptr_r, page_r) |-> rd_val == regbank_pkg::READ_ZERO;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_w1c;
    @(posedge core_clk) disable iff (!rst_b)
    (wr_stb && ptr_r == regbank_pkg::ADDR_EVENT_STAT && shift_r[0] && !(en_q_r && !pins.en_pin))
      |=> !stat_r[regbank_pkg::STAT_OFFEVT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");

  property p_load_first;
    @(posedge core_clk) disable iff (!rst_b)
    !loaded_r |=> loaded_r && (three_r ==
      (($past(fuse_program_supply)) ? regbank_pkg::CTRL_BUILTIN : {3'h0, $past(fuse_reg_three)}));
  endproperty
  a_load_first: assert property (p_load_first) else $error("fuse load wrong");

endmodule

// File: verification/i2c_host.sv
// Host model for the two-wire control bus, timed in ns.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
module i2c_host (
  // Bus pins
  output logic      scl = 1'b1,
  output logic      sda_low = 1'b0,
  input  wire logic sda
);
  // Half period kept above the ten-clock minimum the synchroniser needs
  localparam int HALF = 480;
  // Start, or repeated start from a low clock
  task automatic start();
    sda_low <= 1'b0;
    #HALF scl <= 1'b1;
    #HALF sda_low <= 1'b1;
    #HALF scl <= 1'b0;
  endtask
  // Stop: data rises while the clock is high, then a bus-free gap
  task automatic stop();
    sda_low <= 1'b1;
    #HALF scl <= 1'b1;
    #HALF sda_low <= 1'b0;
    #HALF;
  endtask
  // Eight data bits MSB first plus the ack bit; samples the wire mid-high
  // An ack bit of 1 leaves the wire released for the device
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !d[i];
      #HALF scl <= 1'b1;
      #(HALF/2) q[i] = sda;
      #(HALF/2) scl <= 1'b0;
    end
  endtask
endmodule

// File: verification/test_paged_regulator_control_regs.sv
// Self-checking bench for the paged regulator control bank.
// Assumes the host model drives the bus; the bench resolves the pull-up.
`timescale 1ns/1ns
module test_paged_regulator_control_regs;
  // Pins and bench state
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       en_pin = 1'b1;
  logic       standby_pin = 1'b0;
  logic       lowpower_req = 1'b0;
  logic       fuse_program_supply = 1'b0;
  logic [4:0] fuse_reg_three = 5'h00;
  logic [4:0] fuse_reg_four = 5'h00;
  logic       scl_in, sda_out, sda_oe, host_low;
  logic       reg_three_on, reg_three_sleep, reg_three_lowpower;
  logic       reg_four_on, reg_four_sleep, reg_four_lowpower;
  logic [3:0] reg_three_vsel, reg_four_vsel;
  logic [7:0] c3, c4;
  int         num_errors = 0;
  int         tests_run = 0;
  // Open-drain data wire, high unless someone pulls it
  wire        sda_in = !(host_low || (sda_oe && !sda_out));
  wire  [7:0] p3 = {1'b0, reg_three_on, reg_three_sleep, reg_three_lowpower, reg_three_vsel};
  wire  [7:0] p4 = {1'b0, reg_four_on, reg_four_sleep, reg_four_lowpower, reg_four_vsel};
  always #20 core_clk = !core_clk;
  regulator_ctrl_bank i_dut (.core_clk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe, .en_pin,
    .standby_pin, .lowpower_req, .fuse_program_supply, .fuse_reg_three, .fuse_reg_four,
    .reg_three_on, .reg_three_sleep, .reg_three_lowpower, .reg_three_vsel, .reg_four_on,
    .reg_four_sleep, .reg_four_lowpower, .reg_four_vsel);
  i2c_host i_host (.scl(scl_in), .sda_low(host_low), .sda(sda_in));
  // Expected regulator pins {0, on, sleep, lowpower, vsel} from the pin levels
  function automatic logic [7:0] want(input logic [7:0] c);
    logic on;
    on = en_pin & c[4] & !(standby_pin & c[5]);
    return {1'b0, on, !en_pin & c[7], on & lowpower_req & c[6], c[3:0]};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      $display("BAD %s exp %h saw %h", n, e, s);
      num_errors++;
    end
  endtask
  // Full write: address, register pointer, one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [8:0] q;
    i_host.start();
    i_host.xfer({regbank_pkg::DEV_ADDR, 2'b01}, q);
    i_host.xfer({a, 1'b1}, q);
    i_host.xfer({d, 1'b1}, q);
    i_host.stop();
  endtask
  // Pointer write, repeated start, one byte read with a closing nack
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [8:0] q;
    i_host.start();
    i_host.xfer({regbank_pkg::DEV_ADDR, 2'b01}, q);
    i_host.xfer({a, 1'b1}, q);
    i_host.start();
    i_host.xfer({regbank_pkg::DEV_ADDR, 2'b11}, q);
    i_host.xfer(9'h1FF, q);
    i_host.stop();
    cmp("register read", e, q[8:1]);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Hang guard, well beyond the expected run of about 35k clocks
  initial begin
    #2400000;
    num_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    void'($urandom(74));
    fuse_reg_three <= 5'($urandom);
    fuse_reg_four <= 5'($urandom);
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge core_clk);
    rdc(regbank_pkg::ADDR_THREE_CTRL, {3'h0, fuse_reg_three});
    rdc(regbank_pkg::ADDR_FOUR_CTRL, {3'h0, fuse_reg_four});
    // Corner values first, then random ones, across every pin mode
    for (int i = 0; i < 4; i++) begin
      c3 = (i == 0) ? 8'hFF : 8'($urandom);
      c4 = (i == 0) ? 8'h00 : 8'($urandom);
      wr(regbank_pkg::ADDR_THREE_CTRL, c3);
      wr(regbank_pkg::ADDR_FOUR_CTRL, c4);
      rdc(regbank_pkg::ADDR_THREE_CTRL, c3);
      rdc(regbank_pkg::ADDR_FOUR_CTRL, c4);
      for (int m = 0; m < 3; m++) begin
        @(posedge core_clk);
        en_pin <= (m != 2);
        standby_pin <= (m == 1);
        lowpower_req <= 1'($urandom);
        repeat (12) @(posedge core_clk); // Sync plus output flop latency
        cmp("reg three pins", want(c3), p3);
        cmp("reg four pins", want(c4), p4);
      end
    end
    @(posedge core_clk);
    en_pin <= 1'b1;
    standby_pin <= 1'b0;
    repeat (12) @(posedge core_clk);
    rdc(regbank_pkg::ADDR_EVENT_STAT, 8'h03);
    wr(regbank_pkg::ADDR_EVENT_STAT, 8'h00);
    rdc(regbank_pkg::ADDR_EVENT_STAT, 8'h03);
    wr(regbank_pkg::ADDR_EVENT_STAT, 8'h01);
    rdc(regbank_pkg::ADDR_EVENT_STAT, 8'h02);
    wr(8'h73, 8'h55);
    rdc(8'h73, 8'h00);
    wr(regbank_pkg::ADDR_PAGE_SEL, 8'h01);
    wr(regbank_pkg::ADDR_EXT_SCRATCH, 8'hA5);
    wr(regbank_pkg::ADDR_PAGE_SEL, 8'hF2);
    wr(regbank_pkg::ADDR_EXT_SCRATCH, 8'h5A);
    rdc(regbank_pkg::ADDR_PAGE_SEL, 8'h02);
    rdc(regbank_pkg::ADDR_EXT_SCRATCH, 8'h5A);
    rdc(regbank_pkg::ADDR_THREE_CTRL, c3);
    wr(regbank_pkg::ADDR_PAGE_SEL, 8'h01);
    rdc(regbank_pkg::ADDR_EXT_SCRATCH, 8'hA5);
    wr(regbank_pkg::ADDR_PAGE_SEL, 8'h03);
    rdc(regbank_pkg::ADDR_EXT_SCRATCH, 8'h00);
    wr(regbank_pkg::ADDR_PAGE_SEL, 8'h00);
    rdc(regbank_pkg::ADDR_EXT_SCRATCH, 8'h00);
    // Second reset with the programming supply up: built-in defaults
    @(posedge core_clk);
    rst_b <= 1'b0;
    fuse_program_supply <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge core_clk);
    rdc(regbank_pkg::ADDR_FOUR_CTRL, regbank_pkg::CTRL_BUILTIN);
    tally_and_finish();
  end
endmodule
